// file: core/epw_core.sv
// Enhanced PWM unit one with its period timer, dead band, steering and auto-shutdown.
// Assumes a plain register port on CLK_IN and fault sources arriving asynchronously from pins.
//
// Overview of operation
// - Timer select 00 picks the period timer.
// - Period comes from the period value register.
// - Source field disables or selects shutdown trigger.
// - Two fields give pair A/C, B/D states.
// - Setting status bit forces the shutdown state.
// - Output config selects single, half, full bridge.
// - Mode select low bits set output polarity.
// - Duty is high register plus two bits.
// - Half bridge applies seven-bit dead band.
// - Timer counts through prescaler while run set.
// - Auto restart resumes once condition clears.
// - Without auto restart, firmware clear restarts.
// - Steering enables place waveform on pins.
// - Event sets status, forces pins at once.
// - Condition is level; status writes ignored while active.
// - Restart begins at the next period start.
// - Pairs drive high, low or float.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps

module epw_core
  import epw_pkg::*;
#(
  parameter int TCY_CYCLES = EPW_TCY_CYCLES
)
(
  input  wire logic       CLK_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic       CMP1_IN,
  input  wire logic       CMP2_IN,
  input  wire logic       FAULT_N_IN,
  output logic      [3:0] PWM_OUT,
  output logic      [3:0] PWM_OE_OUT
);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0] sd_ctrl_q;
  logic [7:0] pwm_ctrl_q;
  logic [7:0] duty_high_q;
  logic [7:0] pwm_cfg_q;
  logic [7:0] steer_q;
  logic [3:0] steer_act_q;
  logic [1:0] tsel_q;
  logic [7:0] tctrl_q;
  logic [7:0] period_q;
  logic [7:0] duty_lat_q;
  logic [1:0] duty_low_lat_q;

  // Timer and waveform state.
  logic [6:0] tcy_cnt_q;
  logic [3:0] pre_cnt_q;
  logic [7:0] tmr_q;
  logic [1:0] q_cnt_q;
  logic       raw_q;
  logic [6:0] db_cnt_q;
  logic       dly_q;
  logic       hold_q;

  // Fault synchronisers.
  logic [2:0] flt_s1_q;
  logic [2:0] flt_s2_q;

  logic       tcy_tick;
  logic       tmr_en;
  logic       db_done;
  logic       pre_tick;
  logic       period_end;
  logic       cond;
  logic       sw_wr_sd;
  logic [9:0] duty;
  logic [9:0] pos;
  logic [3:0] mod_d;
  logic [3:0] pol_d;
  logic [3:0] en_d;
  logic [3:0] out_d;
  logic [3:0] oe_d;

  // Prescale count for a ratio field: 1, 4, 16.
  function automatic logic [3:0] epw_pre_limit(input logic [1:0] ps);
    case (ps)
      2'h0:    epw_pre_limit = 4'h0;
      2'h1:    epw_pre_limit = 4'h3;
      default: epw_pre_limit = 4'hF;
    endcase
  endfunction

  // Picks a pin level for one pair in shutdown.
  function automatic logic epw_sd_level(input logic [1:0] st);
    epw_sd_level = (st == EPW_DRV_HIGH);
  endfunction

  // ****************************************************************
  // Fault input synchronisers.
  // ****************************************************************
  // Two stages per source; only the second stage is read.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      flt_s1_q <= 3'h0;
      flt_s2_q <= 3'h0;
    end
    else
    begin
      flt_s1_q <= {~FAULT_N_IN, CMP2_IN, CMP1_IN};
      flt_s2_q <= flt_s1_q;
    end
  end

  // Source field selects which active levels count as a condition.
  always_comb
  begin
    case (sd_ctrl_q[EPW_SD_SRC_LSB +: 3])
      EPW_SRC_OFF:      cond = 1'b0;
      EPW_SRC_CMP1:     cond = flt_s2_q[0];
      EPW_SRC_CMP2:     cond = flt_s2_q[1];
      EPW_SRC_CMP12:    cond = flt_s2_q[0] | flt_s2_q[1];
      EPW_SRC_FAULT:    cond = flt_s2_q[2];
      EPW_SRC_FLT_CMP1: cond = flt_s2_q[2] | flt_s2_q[0];
      EPW_SRC_FLT_CMP2: cond = flt_s2_q[2] | flt_s2_q[1];
      default:          cond = |flt_s2_q;
    endcase
  end

  assign sw_wr_sd = WR_IN && (ADDR_IN == EPW_OFS_SHUTDOWN_CTRL);

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  // Plain configuration registers.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      pwm_ctrl_q  <= EPW_RST_ZERO;
      duty_high_q <= EPW_RST_ZERO;
      pwm_cfg_q   <= EPW_RST_ZERO;
      steer_q     <= EPW_RST_STEERING;
      tsel_q      <= EPW_TSEL_TIMER2;
      tctrl_q     <= EPW_RST_ZERO;
      period_q    <= EPW_RST_PERIOD;
    end
    else if (WR_IN)
    begin
      case (ADDR_IN)
        EPW_OFS_PWM_CTRL:     pwm_ctrl_q  <= WDATA_IN;
        EPW_OFS_DUTY_HIGH:    duty_high_q <= WDATA_IN;
        EPW_OFS_PWM_CONFIG:   pwm_cfg_q   <= WDATA_IN;
        EPW_OFS_STEERING:     steer_q     <= {3'h0, WDATA_IN[4:0]};
        EPW_OFS_TIMER_SELECT: tsel_q      <= WDATA_IN[EPW_TS_SEL_LSB +: 2];
        EPW_OFS_TIMER_CTRL:   tctrl_q     <= {5'h0, WDATA_IN[2:0]};
        EPW_OFS_PERIOD_VALUE: period_q    <= WDATA_IN;
        default:              ;
      endcase
    end
  end

  // Event status: a live condition sets it and wins over any write.
  // With auto restart the bit falls by itself once the condition is gone.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      sd_ctrl_q <= EPW_RST_ZERO;
    else
    begin
      if (sw_wr_sd)
        sd_ctrl_q[6:0] <= WDATA_IN[6:0];
      if (cond)
        sd_ctrl_q[EPW_SD_STATUS_BIT] <= 1'b1;
      else if (sw_wr_sd)
        sd_ctrl_q[EPW_SD_STATUS_BIT] <= WDATA_IN[EPW_SD_STATUS_BIT];
      else if (pwm_cfg_q[EPW_CF_RESTART_BIT])
        sd_ctrl_q[EPW_SD_STATUS_BIT] <= 1'b0;
    end
  end

  // ****************************************************************
  // Period timer.
  // ****************************************************************
  assign tmr_en     = tctrl_q[EPW_TC_RUN_BIT] && (tsel_q == EPW_TSEL_TIMER2);
  assign pre_tick   = tmr_en && (pre_cnt_q == epw_pre_limit(tctrl_q[EPW_TC_PRE_LSB +: 2]));
  assign period_end = pre_tick && (q_cnt_q == 2'h3) && (tmr_q == period_q);

  // Prescaler and timer; gating by the run bit keeps a stopped timer from faking a period end.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      pre_cnt_q <= 4'h0;
      tmr_q     <= 8'h00;
      q_cnt_q   <= 2'h0;
    end
    else if (tmr_en)
    begin
      pre_cnt_q <= pre_tick ? 4'h0 : pre_cnt_q + 4'h1;
      if (pre_tick)
      begin
        q_cnt_q <= q_cnt_q + 2'h1;
        if (q_cnt_q == 2'h3)
          tmr_q <= (tmr_q == period_q) ? 8'h00 : tmr_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Waveform, dead band and restart hold.
  // ****************************************************************
  assign duty = {duty_lat_q, duty_low_lat_q};
  assign pos  = {tmr_q, q_cnt_q};

  // Duty is latched at period start so a half-written value never shows.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      duty_lat_q     <= 8'h00;
      duty_low_lat_q <= 2'h0;
      raw_q          <= 1'b0;
      steer_act_q    <= EPW_RST_STEERING[3:0];
    end
    else
    begin
      if (period_end)
      begin
        duty_lat_q     <= duty_high_q;
        duty_low_lat_q <= pwm_ctrl_q[EPW_PC_DUTY_LSB +: 2];
        raw_q          <= ({duty_high_q, pwm_ctrl_q[EPW_PC_DUTY_LSB +: 2]} != 10'h000);
      end
      else if (pre_tick && (pos + 10'h001 == duty))
        raw_q <= 1'b0;
      if (!steer_q[EPW_ST_SYNC_BIT] || period_end)
        steer_act_q <= steer_q[3:0];
    end
  end

  // Dead band delays the inactive-to-active edge by whole instruction cycles timed from the edge itself.
  assign tcy_tick = (tcy_cnt_q == 7'(TCY_CYCLES - 1));
  assign db_done  = (raw_q != dly_q) && (db_cnt_q >= pwm_cfg_q[6:0]);
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      tcy_cnt_q <= 7'h00;
      db_cnt_q  <= 7'h00;
      dly_q     <= 1'b0;
    end
    else if (pwm_ctrl_q[EPW_PC_CFG_LSB +: 2] != EPW_CFG_HALF || raw_q == dly_q)
    begin
      tcy_cnt_q <= 7'h00;
      db_cnt_q  <= 7'h00;
      dly_q     <= raw_q;
    end
    else if (db_done)
      dly_q <= raw_q;
    else if (tcy_tick)
    begin
      tcy_cnt_q <= 7'h00;
      db_cnt_q  <= db_cnt_q + 7'h01;
    end
    else
      tcy_cnt_q <= tcy_cnt_q + 7'h01;
  end

  // Once shutdown ends the outputs stay parked until a fresh period begins.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      hold_q <= 1'b0;
    else if (sd_ctrl_q[EPW_SD_STATUS_BIT])
      hold_q <= 1'b1;
    else if (period_end)
      hold_q <= 1'b0;
  end

  // Modulated levels per pin, before polarity, for each configuration.
  always_comb
  begin
    case (pwm_ctrl_q[EPW_PC_CFG_LSB +: 2])
      EPW_CFG_SINGLE:   mod_d = {4{raw_q}} & steer_act_q;
      EPW_CFG_HALF:     mod_d = {2'b00, ~raw_q & (~dly_q | db_done), raw_q & (dly_q | db_done)};
      EPW_CFG_FULL_FWD: mod_d = {raw_q, 2'b00, 1'b1};
      default:          mod_d = {1'b0, 1'b1, raw_q, 1'b0};
    endcase
    case (pwm_ctrl_q[EPW_PC_CFG_LSB +: 2])
      EPW_CFG_SINGLE: en_d = steer_act_q;
      EPW_CFG_HALF:   en_d = 4'b0011;
      default:        en_d = 4'b1111;
    endcase
    // Bit 1 inverts A/C, bit 0 inverts B/D.
    pol_d = {pwm_ctrl_q[0], pwm_ctrl_q[1], pwm_ctrl_q[0], pwm_ctrl_q[1]};
    if (pwm_ctrl_q[3:2] != EPW_PWM_MODE_BITS)
      en_d = 4'h0;
  end

  // Pin drive: shutdown overrides the waveform on enabled pins only.
  always_comb
  begin
    out_d = mod_d ^ pol_d;
    oe_d  = en_d;
    if (cond || sd_ctrl_q[EPW_SD_STATUS_BIT] || hold_q)
    begin
      out_d = {epw_sd_level(sd_ctrl_q[1:0]), epw_sd_level(sd_ctrl_q[3:2]),
               epw_sd_level(sd_ctrl_q[1:0]), epw_sd_level(sd_ctrl_q[3:2])};
      oe_d  = en_d & {~sd_ctrl_q[1], ~sd_ctrl_q[3], ~sd_ctrl_q[1], ~sd_ctrl_q[3]};
    end
  end

  // Outputs registered; the condition path bypasses the status flop so pins react on the first edge.
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      PWM_OUT    <= 4'h0;
      PWM_OE_OUT <= 4'h0;
    end
    else
    begin
      PWM_OUT    <= out_d;
      PWM_OE_OUT <= oe_d;
    end
  end

  // ****************************************************************
  // Read port.
  // ****************************************************************
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN)
    begin
      case (ADDR_IN)
        EPW_OFS_SHUTDOWN_CTRL: RDATA_OUT <= sd_ctrl_q;
        EPW_OFS_PWM_CTRL:      RDATA_OUT <= pwm_ctrl_q;
        EPW_OFS_DUTY_HIGH:     RDATA_OUT <= duty_high_q;
        EPW_OFS_PWM_CONFIG:    RDATA_OUT <= pwm_cfg_q;
        EPW_OFS_STEERING:      RDATA_OUT <= steer_q;
        EPW_OFS_TIMER_SELECT:  RDATA_OUT <= {6'h00, tsel_q};
        EPW_OFS_TIMER_CTRL:    RDATA_OUT <= tctrl_q;
        EPW_OFS_PERIOD_VALUE:  RDATA_OUT <= period_q;
        EPW_OFS_TIMER_COUNT:   RDATA_OUT <= tmr_q;
        default:               RDATA_OUT <= 8'h00;
      endcase
    end
    else
      RDATA_OUT <= 8'h00;
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  status_sticky_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    cond |=> sd_ctrl_q[EPW_SD_STATUS_BIT])
    else $error("Status bit not set during condition.");

  force_sd_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    sd_ctrl_q[EPW_SD_STATUS_BIT] |=> (PWM_OE_OUT == ($past(en_d) & ~{2{$past(sd_ctrl_q[1]), $past(sd_ctrl_q[3])}}))
      && (PWM_OUT == {2{$past(sd_ctrl_q[1:0]) == EPW_DRV_HIGH, $past(sd_ctrl_q[3:2]) == EPW_DRV_HIGH}}))
    else $error("Shutdown drive not applied.");

  auto_restart_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (!cond && !sw_wr_sd && pwm_cfg_q[EPW_CF_RESTART_BIT]) |=> !sd_ctrl_q[EPW_SD_STATUS_BIT])
    else $error("Auto restart did not clear status.");

  manual_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (sd_ctrl_q[EPW_SD_STATUS_BIT] && !sw_wr_sd && !pwm_cfg_q[EPW_CF_RESTART_BIT])
      |=> sd_ctrl_q[EPW_SD_STATUS_BIT])
    else $error("Status fell without firmware clear.");

  restart_period_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (hold_q && !sd_ctrl_q[EPW_SD_STATUS_BIT] && !period_end) |=> hold_q)
    else $error("Waveform resumed before period start.");

  timer_stop_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !tctrl_q[EPW_TC_RUN_BIT] |=> $stable(tmr_q))
    else $error("Timer moved while stopped.");

  period_wrap_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    period_end |=> tmr_q == 8'h00)
    else $error("Timer did not wrap at period.");

  single_steer_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (pwm_ctrl_q[7:6] == EPW_CFG_SINGLE && pwm_ctrl_q[3:2] == EPW_PWM_MODE_BITS)
      |=> (PWM_OE_OUT & ~$past(steer_act_q)) == 4'h0)
    else $error("Unsteered pin driven.");

endmodule

// file: common/epw_pkg.sv
// Package for the enhanced PWM unit: register offsets, field positions, reset values and timing counts.
// Assumes a plain register port with 8-bit registers at small word indices.
package epw_pkg;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [3:0] EPW_OFS_SHUTDOWN_CTRL   = 4'h0;
  localparam logic [3:0] EPW_OFS_PWM_CTRL        = 4'h1;
  localparam logic [3:0] EPW_OFS_DUTY_HIGH       = 4'h2;
  localparam logic [3:0] EPW_OFS_PWM_CONFIG      = 4'h3;
  localparam logic [3:0] EPW_OFS_STEERING        = 4'h4;
  localparam logic [3:0] EPW_OFS_TIMER_SELECT    = 4'h5;
  localparam logic [3:0] EPW_OFS_TIMER_CTRL      = 4'h6;
  localparam logic [3:0] EPW_OFS_PERIOD_VALUE    = 4'h7;
  localparam logic [3:0] EPW_OFS_TIMER_COUNT     = 4'h8;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int EPW_SD_STATUS_BIT  = 7;
  localparam int EPW_SD_SRC_LSB     = 4;
  localparam int EPW_SD_AC_LSB      = 2;
  localparam int EPW_SD_BD_LSB      = 0;
  localparam int EPW_PC_CFG_LSB     = 6;
  localparam int EPW_PC_DUTY_LSB    = 4;
  localparam int EPW_PC_MODE_LSB    = 0;
  localparam int EPW_CF_RESTART_BIT = 7;
  localparam int EPW_ST_SYNC_BIT    = 4;
  localparam int EPW_TS_SEL_LSB     = 0;
  localparam int EPW_TC_RUN_BIT     = 2;
  localparam int EPW_TC_PRE_LSB     = 0;

  // ****************************************************************
  // Reset values and encodings.
  // ****************************************************************
  localparam logic [7:0] EPW_RST_ZERO      = 8'h00;
  localparam logic [7:0] EPW_RST_STEERING  = 8'h01;
  localparam logic [7:0] EPW_RST_PERIOD    = 8'hFF;
  localparam logic [1:0] EPW_TSEL_TIMER2   = 2'h0;
  localparam logic [1:0] EPW_CFG_SINGLE    = 2'h0;
  localparam logic [1:0] EPW_CFG_FULL_FWD  = 2'h1;
  localparam logic [1:0] EPW_CFG_HALF      = 2'h2;
  localparam logic [1:0] EPW_CFG_FULL_REV  = 2'h3;
  localparam logic [1:0] EPW_PWM_MODE_BITS = 2'h3;
  localparam logic [1:0] EPW_DRV_LOW       = 2'h0;
  localparam logic [1:0] EPW_DRV_HIGH      = 2'h1;
  localparam logic [2:0] EPW_SRC_OFF       = 3'h0;
  localparam logic [2:0] EPW_SRC_CMP1      = 3'h1;
  localparam logic [2:0] EPW_SRC_CMP2      = 3'h2;
  localparam logic [2:0] EPW_SRC_CMP12     = 3'h3;
  localparam logic [2:0] EPW_SRC_FAULT     = 3'h4;
  localparam logic [2:0] EPW_SRC_FLT_CMP1  = 3'h5;
  localparam logic [2:0] EPW_SRC_FLT_CMP2  = 3'h6;
  localparam logic [2:0] EPW_SRC_ALL       = 3'h7;

  // ****************************************************************
  // Timing: one instruction cycle is four oscillator periods.
  // ****************************************************************
  localparam int EPW_CLK_MHZ      = 50;
  localparam int EPW_TCY_NS       = 80;
  localparam int EPW_TCY_CYCLES   = (EPW_TCY_NS * EPW_CLK_MHZ + 999) / 1000;

endpackage

// file: sim/epw_power_stage.sv
// Far-side model: bridge switch drivers with board pull-downs, two comparators and a fault pin.
// Assumes the bench sets trip levels and pin directions just after a rising clock edge.
`timescale 1ns/1ps

module epw_power_stage
(
  input  wire logic [3:0] pwm_in,
  input  wire logic [3:0] pwm_oe_in,
  input  wire logic [3:0] dir_out_in,
  input  wire logic [2:0] trip_in,
  output logic      [3:0] pin_out,
  output logic            cmp1_out,
  output logic            cmp2_out,
  output logic            fault_n_out
);
  // A pin that nobody drives sinks to its pull-down, never to the last driven level.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pin_out[i] = (dir_out_in[i] && pwm_oe_in[i]) ? pwm_in[i] : 1'b0;
    end
  end

  // Comparators sit on analog inputs; the fault pin is a digital input pulled high.
  assign cmp1_out    = trip_in[0];
  assign cmp2_out    = trip_in[1];
  assign fault_n_out = ~trip_in[2];
endmodule

// file: sim/tb_epw_core.sv
// Self-checking bench for the PWM core: registers, waveforms, shutdown and restart.
// Assumes the power stage model on the pins and four clocks per instruction cycle.
`timescale 1ns/1ps

module tb_epw_core
  import epw_pkg::*;
;
  typedef struct {
    logic [3:0] a;
    logic [7:0] d;
    int         hi [4];
  } epw_row_t;

  logic       clk;
  logic       rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [3:0] pwm;
  logic [3:0] oe;
  logic [3:0] pins;
  logic [3:0] dir_out;
  logic [2:0] trip;
  logic       cmp1;
  logic       cmp2;
  logic       fault_n;
  logic [7:0] rdat;
  int         hi_cnt [4];
  int         cyc;
  int         mismatches;
  int         compares;
  logic [7:0] ref_rst [9] = '{EPW_RST_ZERO, EPW_RST_ZERO, EPW_RST_ZERO, EPW_RST_ZERO,
                              EPW_RST_STEERING, EPW_RST_ZERO, EPW_RST_ZERO, EPW_RST_PERIOD, EPW_RST_ZERO};
  // Each row builds on the one before; high counts are per 40-clock period, pins A to D.
  epw_row_t   rows [10] = '{
    '{EPW_OFS_STEERING,   8'h0F, '{22, 22, 22, 22}},
    '{EPW_OFS_PWM_CTRL,   8'h2E, '{18, 22, 18, 22}},
    '{EPW_OFS_PWM_CTRL,   8'h2F, '{18, 18, 18, 18}},
    '{EPW_OFS_PWM_CTRL,   8'h2C, '{22, 22, 22, 22}},
    '{EPW_OFS_DUTY_HIGH,  8'h07, '{30, 30, 30, 30}},
    '{EPW_OFS_PWM_CTRL,   8'h3C, '{31, 31, 31, 31}},
    '{EPW_OFS_PWM_CTRL,   8'h7C, '{40, 0, 0, 31}},
    '{EPW_OFS_PWM_CTRL,   8'hFC, '{0, 31, 40, 0}},
    '{EPW_OFS_PWM_CTRL,   8'hBC, '{31, 9, 0, 0}},
    '{EPW_OFS_PWM_CONFIG, 8'h01, '{27, 5, 0, 0}}
  };

  epw_core #(.TCY_CYCLES(4)) u_epw_core (
    .CLK_IN     (clk),
    .RESET_N_IN (rst_n),
    .ADDR_IN    (addr),
    .WDATA_IN   (wdata),
    .WR_IN      (wr),
    .RD_IN      (rd),
    .RDATA_OUT  (rdata),
    .CMP1_IN    (cmp1),
    .CMP2_IN    (cmp2),
    .FAULT_N_IN (fault_n),
    .PWM_OUT    (pwm),
    .PWM_OE_OUT (oe)
  );

  epw_power_stage u_epw_power_stage (
    .pwm_in      (pwm),
    .pwm_oe_in   (oe),
    .dir_out_in  (dir_out),
    .trip_in     (trip),
    .pin_out     (pins),
    .cmp1_out    (cmp1),
    .cmp2_out    (cmp2),
    .fault_n_out (fault_n)
  );

  // 50 MHz system clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // Bus, measurement and reporting tasks.
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && compares > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic measure(input int n);
    hi_cnt = '{default: 0};
    repeat (n)
    begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++)
      begin
        hi_cnt[i] += int'(pins[i]);
      end
    end
  endtask

  task automatic wait_rise(input int i);
    logic prev;
    prev = pins[i];
    cyc = 0;
    while (!(pins[i] === 1'b1 && prev === 1'b0))
    begin
      prev = pins[i];
      @(posedge clk);
      #1;
      cyc++;
      if (cyc > 2000)
      begin
        check("rise wait", 16'h0000, 16'h0001);
        end_sim();
      end
    end
  endtask

  task automatic period_is(input int n);
    repeat (3) wait_rise(0);
    check("period", 16'(cyc), 16'(n));
  endtask

  task automatic timer_pair(input logic still);
    logic [7:0] c1;
    reg_rd(EPW_OFS_TIMER_COUNT, c1);
    repeat (8) @(posedge clk);
    reg_rd(EPW_OFS_TIMER_COUNT, rdat);
    check("timer frozen", 16'(c1 === rdat), 16'(still));
  endtask

  // Unmapped places are written too, so a write that sticks at such a place shows up on its own read.
  task automatic reset_check();
    check("drive at reset", 16'(oe), 16'h0000);
    for (int a = 0; a < 16; a++)
    begin
      if (a > 8)
      begin
        reg_wr(4'(a), 8'hFF);
      end
      reg_rd(4'(a), rdat);
      check("reset value", 16'(rdat), (a < 9) ? 16'(ref_rst[a]) : 16'h0000);
    end
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    mismatches = 0;
    compares   = 0;
    rst_n      = 1'b0;
    addr       = 4'h0;
    wdata      = 8'h00;
    wr         = 1'b0;
    rd         = 1'b0;
    dir_out    = 4'h0;
    trip       = 3'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reset_check();
    // Set up with the pins still inputs, starting from a forced shutdown.
    reg_wr(EPW_OFS_STEERING, 8'h01);
    reg_wr(EPW_OFS_TIMER_SELECT, {6'h00, EPW_TSEL_TIMER2});
    reg_wr(EPW_OFS_PERIOD_VALUE, 8'h09);
    reg_wr(EPW_OFS_SHUTDOWN_CTRL, 8'h80);
    reg_wr(EPW_OFS_PWM_CONFIG, 8'h00);
    reg_wr(EPW_OFS_PWM_CTRL, 8'h2C);
    reg_wr(EPW_OFS_DUTY_HIGH, 8'h05);
    reg_wr(EPW_OFS_TIMER_CTRL, 8'h04);
    @(posedge clk);
    dir_out <= 4'hF;
    reg_wr(EPW_OFS_SHUTDOWN_CTRL, 8'h00);
    foreach (rows[r])
    begin
      reg_wr(rows[r].a, rows[r].d);
      reg_rd(rows[r].a, rdat);
      check("readback", 16'(rdat), 16'(rows[r].d));
      repeat (100) @(posedge clk);
      measure(40);
      for (int i = 0; i < 4; i++)
      begin
        check("high time", 16'(hi_cnt[i]), 16'(rows[r].hi[i]));
      end
    end
    // Timer stops when deselected or not running.
    reg_wr(EPW_OFS_TIMER_SELECT, 8'h01);
    timer_pair(1'b1);
    reg_wr(EPW_OFS_TIMER_SELECT, 8'h00);
    timer_pair(1'b0);
    reg_wr(EPW_OFS_TIMER_CTRL, 8'h00);
    timer_pair(1'b1);
    reg_wr(EPW_OFS_TIMER_CTRL, 8'h04);
    // Period follows the period value and the prescaler.
    reg_wr(EPW_OFS_PWM_CTRL, 8'h3C);
    reg_wr(EPW_OFS_PWM_CONFIG, 8'h00);
    period_is(40);
    reg_wr(EPW_OFS_PERIOD_VALUE, 8'h13);
    period_is(80);
    reg_wr(EPW_OFS_PERIOD_VALUE, 8'h09);
    reg_wr(EPW_OFS_TIMER_CTRL, 8'h05);
    period_is(160);
    reg_wr(EPW_OFS_TIMER_CTRL, 8'h06);
    period_is(640);
    reg_wr(EPW_OFS_TIMER_CTRL, 8'h04);
    // Every pair of safe states under a forced shutdown on all four pins.
    reg_wr(EPW_OFS_STEERING, 8'h0F);
    for (int ac = 0; ac < 3; ac++)
    begin
      for (int bd = 0; bd < 3; bd++)
      begin
        reg_wr(EPW_OFS_SHUTDOWN_CTRL, 8'(8'h80 | (ac << 2) | bd));
        repeat (3) @(posedge clk);
        #1;
        check("pin state", 16'(pins), 16'({bd == 1, ac == 1, bd == 1, ac == 1}));
        check("pin drive", 16'(oe), 16'({bd != 2, ac != 2, bd != 2, ac != 2}));
      end
    end
    // Every source code against every trip input, with restart left to firmware.
    for (int code = 0; code < 8; code++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        reg_wr(EPW_OFS_SHUTDOWN_CTRL, 8'((code << 4) | 5));
        trip <= 3'(1 << k);
        repeat (4) @(posedge clk);
        #1;
        if (code[k])
        begin
          check("shutdown pins", 16'(pins), 16'h000F);
        end
        reg_wr(EPW_OFS_SHUTDOWN_CTRL, 8'((code << 4) | 5));
        reg_rd(EPW_OFS_SHUTDOWN_CTRL, rdat);
        check("status held", 16'(rdat[7]), 16'(code[k]));
        @(posedge clk);
        trip <= 3'h0;
        repeat (4) @(posedge clk);
        reg_rd(EPW_OFS_SHUTDOWN_CTRL, rdat);
        check("status kept", 16'(rdat[7]), 16'(code[k]));
        reg_wr(EPW_OFS_SHUTDOWN_CTRL, 8'((code << 4) | 5));
        reg_rd(EPW_OFS_SHUTDOWN_CTRL, rdat);
        check("status cleared", 16'(rdat[7]), 16'h0000);
      end
    end
    // Auto restart on the fault pin; the first pulse after it must be whole.
    reg_wr(EPW_OFS_SHUTDOWN_CTRL, {1'b0, EPW_SRC_FAULT, 4'h0});
    reg_wr(EPW_OFS_PWM_CONFIG, 8'h80);
    trip <= 3'h4;
    repeat (4) @(posedge clk);
    reg_rd(EPW_OFS_SHUTDOWN_CTRL, rdat);
    check("status auto", 16'(rdat[7]), 16'h0001);
    @(posedge clk);
    trip <= 3'h0;
    repeat (6) @(posedge clk);
    reg_rd(EPW_OFS_SHUTDOWN_CTRL, rdat);
    check("status auto off", 16'(rdat[7]), 16'h0000);
    wait_rise(0);
    cyc = 0;
    while (pins[0] === 1'b1 && cyc < 100)
    begin
      @(posedge clk);
      #1;
      cyc++;
    end
    check("first pulse", 16'(cyc), 16'd31);
    // Leaving PWM mode releases every pin.
    reg_wr(EPW_OFS_PWM_CTRL, 8'h30);
    repeat (2) @(posedge clk);
    #1;
    check("drive off", 16'(oe), 16'h0000);
    // A second reset in mid-run must bring back every reset value.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reset_check();
    end_sim();
  end
endmodule
